// ===== design/bus_exchanger_regs.vh
// Purpose: Shared constants for the registered 18-to-36 bus exchanger.
// Assumes: Included by its bare name from the exchanger design file only; the synchroniser file does not include it.
// Notes: No software registers exist; these are widths, bit positions and reset values only.
`ifndef BUS_EXCHANGER_REGS_VH
`define BUS_EXCHANGER_REGS_VH

`define XCHG_HALF_W 18
`define XCHG_WIDE_W 36
`define XCHG_CTRL_W 4
`define XCHG_SYNC_W 58
`define XCHG_NARROW_LSB 40
`define XCHG_LOW_LSB 22
`define XCHG_HIGH_LSB 4
`define XCHG_DIR_BIT 2
`define XCHG_SEL_BIT 1
`define XCHG_DATA_RST 18'h00000
`define XCHG_DIR_RST 1'b0
`define XCHG_OE_N_RST 1'b1
`define XCHG_SEL_RST 1'b0
`define XCHG_LCLK_RST 1'b0

`endif

// ===== design/pin_sync2.v
// Purpose: Two flip-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes: Each bit is a level held for many sys_clk cycles around link clock edges.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
module pin_sync2 #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire sys_clk,
  input wire rstn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_r;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ===== design/bus_exchanger.v
// What this block does
// - Data moves between an 18-bit narrow port and a 36-bit wide port split into two 18-bit halves.
// - Every data and direction register captures only on a rising edge of the link clock.
// - Going wide to narrow, the select input chooses the low or the high half for the narrow port.
// - Going narrow to wide, the low half path has two register stages and the high half one.
// - The direction input is registered so the driven port changes only with the link clock.
// - Narrow to wide with select high, both wide halves keep their previous levels.
// - Narrow to wide with select low, narrow data reaches the low half after the second edge.
// - Wide to narrow, high-half data loads a first stage with select low and moves on with select high.
// - Output enable is active low; high floats both ports, low lets direction pick the driver.
//
// Purpose: Registered bus exchanger behind the pins, clocked by sys_clk at 40 MHz.
// Assumes: The link clock and every pin are asynchronous and are synchronised before use.
// Notes: Outputs lag the pins by a few sys_clk cycles because of synchronisation.
`timescale 1ns/100ps
`include "bus_exchanger_regs.vh"
module bus_exchanger (
  input wire sys_clk,
  input wire rstn,
  input wire link_clk,
  input wire oe_n,
  input wire dir,
  input wire sel,
  input wire [`XCHG_HALF_W-1:0] narrow_in,
  output reg [`XCHG_HALF_W-1:0] narrow_out,
  output reg narrow_oe,
  input wire [`XCHG_HALF_W-1:0] wide_low_half_in,
  output reg [`XCHG_HALF_W-1:0] wide_low_half_out,
  output reg wide_low_half_oe,
  input wire [`XCHG_HALF_W-1:0] wide_high_half_in,
  output reg [`XCHG_HALF_W-1:0] wide_high_half_out,
  output reg wide_high_half_oe
);

  localparam [`XCHG_SYNC_W-1:0] SYNC_RST = {`XCHG_DATA_RST, `XCHG_DATA_RST,
    `XCHG_DATA_RST, `XCHG_OE_N_RST, `XCHG_DIR_RST, `XCHG_SEL_RST, `XCHG_LCLK_RST};

  wire [`XCHG_SYNC_W-1:0] sync_q;
  wire [`XCHG_HALF_W-1:0] narrow_s;
  wire [`XCHG_HALF_W-1:0] low_s;
  wire [`XCHG_HALF_W-1:0] high_s;
  wire oe_n_s;
  wire dir_s;
  wire sel_s;
  wire lclk_s;
  wire [`XCHG_CTRL_W-1:0] ctrl_s;

  // Samples taken one cycle earlier are the values that stood just before the
  // link clock rose, which keeps the pins' hold time from mattering.
  reg [`XCHG_SYNC_W-1:0] prev_r;
  reg lclk_prev_r;
  wire link_edge;

  reg dir_r;
  reg [`XCHG_HALF_W-1:0] a_stage_r;
  reg [`XCHG_HALF_W-1:0] b_stage_r;

  wire [`XCHG_HALF_W-1:0] narrow_p;
  wire [`XCHG_HALF_W-1:0] low_p;
  wire [`XCHG_HALF_W-1:0] high_p;
  wire dir_p;
  wire sel_p;

  // One synchroniser per group keeps each bundle's reset value next to it.
  pin_sync2 #(
    .W(`XCHG_HALF_W),
    .RST(`XCHG_DATA_RST)
  ) u_sync_narrow (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d(narrow_in),
    .q(narrow_s)
  );

  pin_sync2 #(
    .W(`XCHG_HALF_W),
    .RST(`XCHG_DATA_RST)
  ) u_sync_low (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d(wide_low_half_in),
    .q(low_s)
  );

  pin_sync2 #(
    .W(`XCHG_HALF_W),
    .RST(`XCHG_DATA_RST)
  ) u_sync_high (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d(wide_high_half_in),
    .q(high_s)
  );

  pin_sync2 #(
    .W(`XCHG_CTRL_W),
    .RST({`XCHG_OE_N_RST, `XCHG_DIR_RST, `XCHG_SEL_RST, `XCHG_LCLK_RST})
  ) u_sync_ctrl (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d({oe_n, dir, sel, link_clk}),
    .q(ctrl_s)
  );

  assign {oe_n_s, dir_s, sel_s, lclk_s} = ctrl_s;
  assign sync_q = {narrow_s, low_s, high_s, ctrl_s};
  assign narrow_p = prev_r[`XCHG_NARROW_LSB +: `XCHG_HALF_W];
  assign low_p = prev_r[`XCHG_LOW_LSB +: `XCHG_HALF_W];
  assign high_p = prev_r[`XCHG_HIGH_LSB +: `XCHG_HALF_W];
  assign dir_p = prev_r[`XCHG_DIR_BIT];
  assign sel_p = prev_r[`XCHG_SEL_BIT];
  assign link_edge = lclk_s & ~lclk_prev_r;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= SYNC_RST;
      lclk_prev_r <= `XCHG_LCLK_RST;
    end else begin
      prev_r <= sync_q;
      lclk_prev_r <= lclk_s;
    end
  end

  // Next values. A data or direction register that no link edge touches keeps its value, so
  // no stored data or direction can move between edges of the link clock.
  reg dir_nxt;
  reg [`XCHG_HALF_W-1:0] a_stage_nxt;
  reg [`XCHG_HALF_W-1:0] b_stage_nxt;
  reg [`XCHG_HALF_W-1:0] narrow_out_nxt;
  reg [`XCHG_HALF_W-1:0] low_out_nxt;
  reg [`XCHG_HALF_W-1:0] high_out_nxt;
  reg narrow_oe_nxt;
  reg low_oe_nxt;
  reg high_oe_nxt;

  // The direction is taken only on a link edge, never straight from the pin.
  always @* begin
    dir_nxt = dir_r;
    if (link_edge) begin
      dir_nxt = dir_p;
    end
  end

  // Narrow to wide: the low half sits behind two stages, the high half behind
  // one, and select high freezes both halves and the first stage.
  always @* begin
    a_stage_nxt = a_stage_r;
    low_out_nxt = wide_low_half_out;
    high_out_nxt = wide_high_half_out;
    if (link_edge && !sel_p) begin
      a_stage_nxt = narrow_p;
      low_out_nxt = a_stage_r;
      high_out_nxt = narrow_p;
    end
  end

  // Wide to narrow: select low loads the high half into its first stage and
  // passes the low half on; select high moves the stored high half out.
  always @* begin
    b_stage_nxt = b_stage_r;
    narrow_out_nxt = narrow_out;
    if (link_edge) begin
      if (!sel_p) begin
        b_stage_nxt = high_p;
        narrow_out_nxt = low_p;
      end else begin
        narrow_out_nxt = b_stage_r;
      end
    end
  end

  // Enables follow the output enable pin at once but the direction only as
  // captured on a link clock edge, so no bus turns round between edges.
  always @* begin
    narrow_oe_nxt = ~oe_n_s & ~dir_r;
    low_oe_nxt = ~oe_n_s & dir_r;
    high_oe_nxt = ~oe_n_s & dir_r;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dir_r <= `XCHG_DIR_RST;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      a_stage_r <= `XCHG_DATA_RST;
      wide_low_half_out <= `XCHG_DATA_RST;
      wide_high_half_out <= `XCHG_DATA_RST;
    end else begin
      a_stage_r <= a_stage_nxt;
      wide_low_half_out <= low_out_nxt;
      wide_high_half_out <= high_out_nxt;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      b_stage_r <= `XCHG_DATA_RST;
      narrow_out <= `XCHG_DATA_RST;
    end else begin
      b_stage_r <= b_stage_nxt;
      narrow_out <= narrow_out_nxt;
    end
  end

  // Both ports float during reset.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      narrow_oe <= 1'b0;
      wide_low_half_oe <= 1'b0;
      wide_high_half_oe <= 1'b0;
    end else begin
      narrow_oe <= narrow_oe_nxt;
      wide_low_half_oe <= low_oe_nxt;
      wide_high_half_oe <= high_oe_nxt;
    end
  end

endmodule

// ===== verification/bus_exchanger_sva.sv
// Purpose: Port checks for the exchanger.
// Assumes: Pins steady 2 cycles around a link rise.
// Notes: Watches design ports only.
`timescale 1ns/100ps
module bus_exchanger_sva (
  input logic sys_clk,
  input logic rstn,
  input logic link_clk,
  input logic oe_n,
  input logic dir,
  input logic sel,
  input logic narrow_oe,
  input logic wide_low_half_oe,
  input logic wide_high_half_oe,
  input logic [17:0] narrow_in,
  input logic [17:0] narrow_out,
  input logic [17:0] wide_low_half_in,
  input logic [17:0] wide_low_half_out,
  input logic [17:0] wide_high_half_in,
  input logic [17:0] wide_high_half_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_ONE_DRV: assert property (!(narrow_oe && wide_low_half_oe))
    else $error("two drivers");
  AST_HALVES: assert property (wide_low_half_oe == wide_high_half_oe)
    else $error("halves split");
  AST_OE_OFF: assert property (oe_n [*5] |-> !narrow_oe && !wide_high_half_oe)
    else $error("drives while off");
  AST_EDGE: assert property ($changed(narrow_out) |-> $past(link_clk, 2))
    else $error("no link edge");
  AST_HOLD: assert property ($changed(wide_low_half_out) |-> !$past(sel, 2))
    else $error("sel high moved");
  AST_HIGH: assert property ($changed(wide_high_half_out) |->
    !$past(sel, 2) && wide_high_half_out == $past(narrow_in, 2)) else $error("high half");
  AST_LOW: assert property ($changed(wide_high_half_out) |->
    wide_low_half_out == $past(wide_high_half_out)) else $error("low stage");
  AST_NARROW: assert property ($changed(narrow_out) && !$past(sel, 2) |->
    narrow_out == $past(wide_low_half_in, 2)) else $error("narrow low");
endmodule
bind bus_exchanger bus_exchanger_sva u_sva (
  .sys_clk(sys_clk),
  .rstn(rstn),
  .link_clk(link_clk),
  .oe_n(oe_n),
  .dir(dir),
  .sel(sel),
  .narrow_oe(narrow_oe),
  .wide_low_half_oe(wide_low_half_oe),
  .wide_high_half_oe(wide_high_half_oe),
  .narrow_in(narrow_in),
  .narrow_out(narrow_out),
  .wide_low_half_in(wide_low_half_in),
  .wide_low_half_out(wide_low_half_out),
  .wide_high_half_in(wide_high_half_in),
  .wide_high_half_out(wide_high_half_out)
);

// ===== verification/link_master.sv
// Purpose: Far-side master making one link clock pulse per request.
// Assumes: go rises four sys_clk cycles after the pins are set, every 200 ns.
// Notes: The clock stands low between transfers and rises 3 ns after a sys_clk rise.
`timescale 1ns/100ps
module link_master (
  input wire logic go,
  output logic link_clk
);
  initial link_clk = 1'h0;
  always @(posedge go) begin
    #3 link_clk = 1'h1;
    #100 link_clk = 1'h0;
  end
endmodule

// ===== verification/bus_exchanger_tb_top.sv
// Purpose: Random transfers checked against a reference model.
// Assumes: One link pulse per 8-cycle step, a 200 ns link period.
// Notes: Results are compared at both link edges, so the old direction is seen too.
`timescale 1ns/100ps
module bus_exchanger_tb_top;
  logic sys_clk = 0, rstn = 0, go = 0, oe_n = 1, dir = 0, sel = 0, link_clk, noe, loe, hoe;
  logic s, dr, oe, dp = 0;
  logic [17:0] narrow_in = 0, lo_in = 0, hi_in = 0, no, lo_o, hi_o, d, l, h;
  logic [17:0] a = 0, b = 0, n = 0, wl = 0, wh = 0;
  logic [56:0] exp_q[$];
  integer num_errors = 0, checks_done = 0, seed = 32'hB3EC8883, k;
  initial forever #12.5 sys_clk = ~sys_clk;
  link_master u_link_master (.go(go), .link_clk(link_clk));
  bus_exchanger u_bus_exchanger (.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk),
    .oe_n(oe_n), .dir(dir), .sel(sel), .narrow_in(narrow_in), .narrow_out(no),
    .narrow_oe(noe), .wide_low_half_in(lo_in), .wide_low_half_out(lo_o),
    .wide_low_half_oe(loe), .wide_high_half_in(hi_in), .wide_high_half_out(hi_o),
    .wide_high_half_oe(hoe));
  task check(input logic [56:0] seen, input logic [56:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(link_clk) begin
    if (rstn) begin
      if (exp_q.size() == 0) check(57'h0, 57'h1);
      else check({no, lo_o, hi_o, noe, loe, hoe}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'h1;
    repeat (4) @(posedge sys_clk);
    for (k = 0; k < 80; k++) begin
      {s, dr, oe} = 3'($random(seed));
      d = 18'($random(seed));
      l = 18'($random(seed));
      h = 18'($random(seed));
      exp_q.push_back({n, wl, wh, !oe && !dp, !oe && dp, !oe && dp});
      if (!s) begin
        wl = a;
        a = d;
        wh = d;
        b = h;
        n = l;
      end else n = b;
      dp = dr;
      exp_q.push_back({n, wl, wh, !oe && !dr, !oe && dr, !oe && dr});
      narrow_in <= d;
      lo_in <= l;
      hi_in <= h;
      {sel, dir, oe_n} <= {s, dr, oe};
      repeat (4) @(posedge sys_clk);
      go <= 1'h1;
      repeat (2) @(posedge sys_clk);
      go <= 1'h0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (12) @(posedge sys_clk);
    check(57'(exp_q.size()), 57'h0);
    test_done;
  end
endmodule
